// ---- core/pmoo_pkg.sv ----
// Purpose: shared constants and types of the on/off and global shutdown controller
// Assumes: 100 MHz clock, all timing but SEQ_CYCLES derived from CLK_PERIOD_NS
// Notes: long counts are defaults of top module parameters
`default_nettype none
package pmoo_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// times in their own units
	localparam int unsigned T_RST_US = 1000;
	localparam int unsigned T_DBNC_US = 30000;
	localparam int unsigned T_BIAS_READY_US = 10000;
	localparam int unsigned T_WD_TICK_MS = 1000;
	// least times round up, the tick is exact
	localparam int unsigned RST_CYCLES = (T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DBNC_CYCLES = (T_DBNC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BIAS_READY_CYCLES = (T_BIAS_READY_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned WD_TICK_CYCLES = (T_WD_TICK_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned SEQ_CYCLES = 8;
	// watchdog periods in seconds, selected by the 2-bit field
	localparam logic [7:0] WD_PERIOD_S0 = 8'h02;
	localparam logic [7:0] WD_PERIOD_S1 = 8'h08;
	localparam logic [7:0] WD_PERIOD_S2 = 8'h20;
	localparam logic [7:0] WD_PERIOD_S3 = 8'h80;
	localparam logic [1:0] WD_CLEAR_CODE = 2'h1;
	// power key modes
	localparam logic [1:0] KEY_MODE_PUSH = 2'h0;
	localparam logic [1:0] KEY_MODE_SLIDE = 2'h1;
	// power-off event record bit positions
	localparam int unsigned PO_BATT = 0;
	localparam int unsigned PO_RSI = 1;
	localparam int unsigned PO_MR = 2;
	localparam int unsigned PO_WDT = 3;
	localparam int unsigned PO_SFT = 4;
	localparam int unsigned PO_OFF = 5;
	localparam int unsigned PO_THERM = 6;
	localparam int unsigned PO_SHUTDOWN_INPUT = 7;
	localparam int unsigned PO_MAIN_SEQUENCER = 8;
	localparam int unsigned PO_W = 9;
	typedef enum logic [2:0] {
		ST_NO_POWER = 3'h0,
		ST_STANDBY = 3'h1,
		ST_BIAS_WAIT = 3'h2,
		ST_READY = 3'h3,
		ST_POWER_UP = 3'h4,
		ST_ON = 3'h5,
		ST_SLEEP = 3'h6,
		ST_POWER_DOWN = 3'h7
	} pmoo_state_e;
endpackage : pmoo_pkg
`default_nettype wire

// ---- core/pmoo_wdog_if.sv ----
// Purpose: link between the controller and its watchdog
// Assumes: both ends on the same clock
// Notes: ctrl end drives commands, wdog end answers with state
`timescale 1ns/1ns
`default_nettype none
interface pmoo_wdog_if;
	logic enable_wr;
	logic enable_wdata;
	logic enable_fuse;
	logic clear_wr;
	logic [1:0] clear_code;
	logic [1:0] period_sel;
	logic auto_clear;
	logic sleep_seq_off;
	logic reload;
	logic enable;
	logic expired;
	modport ctrl (output enable_wr, enable_wdata, enable_fuse, clear_wr, clear_code, period_sel,
		auto_clear, sleep_seq_off, reload, input enable, expired);
	modport wdog (input enable_wr, enable_wdata, enable_fuse, clear_wr, clear_code, period_sel,
		auto_clear, sleep_seq_off, reload, output enable, expired);
endinterface : pmoo_wdog_if
`default_nettype wire

// ---- core/pmoo_wdog.sv ----
// Purpose: system watchdog, counts seconds while enabled
// Assumes: rst_n already synchronised by the parent
// Notes: enable reloads from the fuse one edge after reset and on register reset
`timescale 1ns/1ns
`default_nettype none
module pmoo_wdog import pmoo_pkg::*; #(
	parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	pmoo_wdog_if.wdog wd
);
	logic loaded_reg, loaded_next;
	logic en_reg, en_next;
	logic exp_reg, exp_next;
	logic [31:0] pre_reg, pre_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] period;
	logic restart;

	// period decode and restart sources
	always_comb begin
		case (wd.period_sel)
			2'h0: period = WD_PERIOD_S0;
			2'h1: period = WD_PERIOD_S1;
			2'h2: period = WD_PERIOD_S2;
			default: period = WD_PERIOD_S3;
		endcase
		restart = (wd.clear_wr && wd.clear_code == WD_CLEAR_CODE)
			|| (wd.enable_wr && wd.enable_wdata && !en_reg)
			|| (wd.auto_clear && wd.sleep_seq_off);
	end

	// enable and count; fuse is caught by a clocked load, never by the reset
	always_comb begin
		loaded_next = 1'b1;
		en_next = en_reg;
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		exp_next = 1'b0;
		if (!loaded_reg || wd.reload) begin
			en_next = wd.enable_fuse;
		end else if (wd.enable_wr) begin
			en_next = wd.enable_wdata;
		end
		if (!en_reg || restart) begin
			pre_next = 32'h0;
			cnt_next = 8'h0;
		end else if (pre_reg == 32'(TICK_CYCLES - 1)) begin
			pre_next = 32'h0;
			if (cnt_reg + 8'h1 == period) begin
				cnt_next = 8'h0;
				exp_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 8'h1;
			end
		end else begin
			pre_next = pre_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loaded_reg <= 1'b0;
			en_reg <= 1'b0;
			exp_reg <= 1'b0;
			pre_reg <= 32'h0;
			cnt_reg <= 8'h0;
		end else begin
			loaded_reg <= loaded_next;
			en_reg <= en_next;
			exp_reg <= exp_next;
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	assign wd.enable = en_reg;
	assign wd.expired = exp_reg;

	a_wdog_restart_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(restart && loaded_reg) |=> (cnt_reg == 8'h0 && pre_reg == 32'h0))
		else $error("watchdog did not restart from zero");
	a_wdog_only_enabled: assert property (@(posedge clk) disable iff (!rst_n)
		(!en_reg) |=> (!exp_reg && cnt_reg == 8'h0))
		else $error("watchdog counted while disabled");
	a_wdog_expiry_period: assert property (@(posedge clk) disable iff (!rst_n)
		exp_reg |-> ($past(cnt_reg) + 8'h1 == $past(period)))
		else $error("watchdog expired off its period");
endmodule : pmoo_wdog
`default_nettype wire

// ---- core/pmoo_ctrl.sv ----
// Purpose: top on/off controller, shutdown classes, reset line, interrupt pin
// Assumes: inputs synchronous to clk; key input already debounced upstream
// Notes: open-drain pins give out and oe_n (low drives); only the reset pin also gives in
// Operation
// - release reset only when all conditions met
// - global shutdown: regulators off, registers reset, record
// - nine causes trigger a global shutdown
// - keep clock alive, wake only when valid
// - these causes shut down then wake automatically
// - these causes shut down to off
// - soft reset without wake waits in standby
// - unsafe supply or bias shuts down immediately
// - watchdog enable defaults from fuse, software sets
// - two-bit field selects watchdog period
// - watchdog expiry drives reset and shuts down
// - watchdog auto clears while sleep sequencer off
// - key mode and polarity from fuses
// - interrupt pin low while unmasked event pending
// - oscillator ok moves start state to standby
// - bias command or wakeup leaves standby
// - bias ready before timer, else immediate shutdown
// - ready powers up only after a wakeup
// - sleep on control fall or sleep enable fall
// - sleep exit on listed wakeup sources
// - held reset input shuts down then wakes
// - reset line open-drain, sensed when not driven
// - event record bits clear only by writing one
`timescale 1ns/1ns
`default_nettype none
module pmoo_ctrl import pmoo_pkg::*; #(
	parameter int unsigned IRQ_W = 8,
	parameter int unsigned RST_CNT = RST_CYCLES,
	parameter int unsigned DBNC_CNT = DBNC_CYCLES,
	parameter int unsigned BIAS_READY_CNT = BIAS_READY_CYCLES,
	parameter int unsigned WD_TICK = WD_TICK_CYCLES,
	parameter int unsigned SEQ_CNT = SEQ_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reset_line_n_in,
	output logic reset_line_n_out,
	output logic reset_line_n_oe_n,
	output logic irq_out_n_out,
	output logic irq_out_n_oe_n,
	input wire logic [IRQ_W-1:0] irq_status,
	input wire logic [IRQ_W-1:0] irq_mask,
	input wire logic osc_ok_signal,
	input wire logic osc_stable,
	input wire logic sequencer_reset_release,
	input wire logic bias_enable_cmd,
	input wire logic bias_ready,
	input wire logic main_battery_reset_low,
	input wire logic main_battery_uvlo,
	input wire logic main_battery_ovlo,
	input wire logic thermal_overload,
	input wire logic shutdown_input,
	input wire logic manual_reset_event,
	input wire logic manual_reset_wake_fuse,
	input wire logic soft_reset_cmd,
	input wire logic soft_reset_wake,
	input wire logic power_off_cmd,
	input wire logic wdog_reset_wake,
	input wire logic main_seq_sw_source,
	input wire logic main_seq_sw_enable,
	input wire logic sleep_seq_sw_source,
	input wire logic sleep_seq_sw_enable,
	input wire logic wdog_enable_fuse,
	input wire logic wdog_enable_wr,
	input wire logic wdog_enable_wdata,
	input wire logic wdog_clear_wr,
	input wire logic [1:0] wdog_clear_field,
	input wire logic [1:0] wdog_period_sel,
	input wire logic wdog_auto_clear,
	input wire logic [1:0] key_mode_fuse,
	input wire logic key_polarity_fuse,
	input wire logic sleep_polarity_fuse,
	input wire logic power_key_input,
	input wire logic sleep_control_input,
	input wire logic sleep_allow,
	input wire logic adapter_present,
	input wire logic alarm_one_event,
	input wire logic alarm_two_event,
	input wire logic sudden_loss_wake,
	input wire logic sudden_loss_wake_en,
	input wire logic wake_mask_key,
	input wire logic wake_mask_alarm_one,
	input wire logic wake_mask_alarm_two,
	input wire logic wake_mask_adapter,
	input wire logic wake_mask_battery,
	input wire logic [PO_W-1:0] power_off_record_clr,
	output logic [PO_W-1:0] power_off_event_record,
	output logic [2:0] onoff_state,
	output logic regulators_off,
	output logic register_reset,
	output logic main_sequencer_up,
	output logic sleep_sequencer_up,
	output logic rtc_keep_alive,
	output logic wake_pending,
	output logic wdog_enable
);
	logic rst_meta_reg, rst_n;
	pmoo_state_e state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [PO_W-1:0] rec_reg, rec_next, cause;
	logic wake_flag_reg, wake_flag_next, wake_seen_reg, wake_seen_next;
	logic regoff_reg, mseq_reg, sseq_reg, rreset_reg, rreset_next;
	logic [4:0] prev_reg, prev_next;
	logic oe_n_reg, oe_n_next, irq_oe_n_reg, irq_oe_n_next;
	logic [31:0] rst_cnt_reg, rst_cnt_next, rsi_cnt_reg, rsi_cnt_next;
	logic rsi_fired_reg, rsi_fired_next, rsi_ev_reg, rsi_ev_next;
	logic key_c, en1_c, key_press, en1_rise, en1_fall;
	logic main_sequencer_rise, main_sequencer_fall, sleep_sequencer_rise, sleep_sequencer_fall, batt_rise;
	logic active, imm, seq_go, auto_wake, wake_sb, wake_sl, sleep_go;
	logic release_ok, pend, sensed;
	pmoo_wdog_if wd ();

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// watchdog commands; auto clear treats sleep sequencer off as processor asleep
	assign wd.enable_wr = wdog_enable_wr;
	assign wd.enable_wdata = wdog_enable_wdata;
	assign wd.enable_fuse = wdog_enable_fuse;
	assign wd.clear_wr = wdog_clear_wr;
	assign wd.clear_code = wdog_clear_field;
	assign wd.period_sel = wdog_period_sel;
	assign wd.auto_clear = wdog_auto_clear;
	assign wd.sleep_seq_off = !sseq_reg;
	assign wd.reload = rreset_reg;

	pmoo_wdog #(.TICK_CYCLES(WD_TICK)) u_wdog (
		.clk(clk),
		.rst_n(rst_n),
		.wd(wd)
	);

	// input conditioning: key polarity and mode, sleep control polarity, edges
	always_comb begin
		key_c = power_key_input ^ key_polarity_fuse;
		en1_c = sleep_polarity_fuse ? sleep_control_input : !sleep_control_input;
		prev_next = {key_c, en1_c, main_seq_sw_enable, sleep_seq_sw_enable, main_battery_uvlo};
		case (key_mode_fuse)
			KEY_MODE_PUSH: key_press = key_c && !prev_reg[4];
			KEY_MODE_SLIDE: key_press = key_c != prev_reg[4];
			default: key_press = key_c;
		endcase
		en1_rise = en1_c && !prev_reg[3];
		en1_fall = !en1_c && prev_reg[3];
		main_sequencer_rise = main_seq_sw_source && main_seq_sw_enable && !prev_reg[2];
		main_sequencer_fall = main_seq_sw_source && !main_seq_sw_enable && prev_reg[2];
		sleep_sequencer_rise = sleep_seq_sw_source && sleep_seq_sw_enable && !prev_reg[1];
		sleep_sequencer_fall = sleep_seq_sw_source && !sleep_seq_sw_enable && prev_reg[1];
		batt_rise = !main_battery_uvlo && prev_reg[0];
	end

	// shutdown causes, classes and wakeup sources
	always_comb begin
		cause = '0;
		cause[PO_BATT] = main_battery_reset_low;
		cause[PO_RSI] = rsi_ev_reg;
		cause[PO_MR] = manual_reset_event;
		cause[PO_WDT] = wd.expired;
		cause[PO_SFT] = soft_reset_cmd;
		cause[PO_OFF] = power_off_cmd;
		cause[PO_THERM] = thermal_overload;
		cause[PO_SHUTDOWN_INPUT] = shutdown_input;
		cause[PO_MAIN_SEQUENCER] = main_sequencer_fall;
		// level causes would loop in standby, so only live states act on them
		active = state_reg inside {ST_BIAS_WAIT, ST_READY, ST_POWER_UP, ST_ON, ST_SLEEP};
		imm = main_battery_uvlo || main_battery_ovlo
			|| (state_reg != ST_NO_POWER && !osc_ok_signal)
			|| (state_reg >= ST_READY && !bias_ready)
			|| (state_reg == ST_BIAS_WAIT && !bias_ready && cnt_reg == 32'(BIAS_READY_CNT - 1));
		seq_go = active && (|cause);
		auto_wake = cause[PO_RSI]
			|| (cause[PO_SFT] && soft_reset_wake)
			|| (cause[PO_WDT] && wdog_reset_wake)
			|| (cause[PO_MR] && manual_reset_wake_fuse);
		// wake from standby needs battery and temperature valid
		wake_sb = ((key_press && wake_mask_key)
			|| (alarm_one_event && wake_mask_alarm_one)
			|| (alarm_two_event && wake_mask_alarm_two)
			|| (sudden_loss_wake && sudden_loss_wake_en)
			|| (adapter_present && wake_mask_adapter)
			|| (batt_rise && wake_mask_battery)
			|| wake_flag_reg || main_sequencer_rise)
			&& !thermal_overload && !main_battery_reset_low;
		wake_sl = (sleep_allow && en1_rise) || (key_press && wake_mask_key)
			|| (alarm_one_event && wake_mask_alarm_one)
			|| (alarm_two_event && wake_mask_alarm_two)
			|| (adapter_present && wake_mask_adapter) || main_sequencer_rise || sleep_sequencer_rise;
		sleep_go = (sleep_allow && en1_fall) || sleep_sequencer_fall;
		pend = |(irq_status & ~irq_mask);
	end

	// state machine; immediate shutdown is checked first
	always_comb begin
		state_next = state_reg;
		wake_flag_next = wake_flag_reg;
		wake_seen_next = wake_seen_reg;
		rreset_next = 1'b0;
		// an immediate shutdown in the same cycle wins, so no sequenced cause is latched
		rec_next = (rec_reg & ~power_off_record_clr) | ((seq_go && !imm) ? cause : '0);
		if (imm && state_reg != ST_NO_POWER) begin
			state_next = ST_NO_POWER;
			rreset_next = 1'b1;
			wake_flag_next = 1'b0;
		end else if (seq_go) begin
			state_next = ST_POWER_DOWN;
			wake_flag_next = auto_wake;
		end else begin
			case (state_reg)
				ST_NO_POWER: begin
					if (osc_ok_signal && !imm) begin
						state_next = ST_STANDBY;
					end
				end
				ST_STANDBY: begin
					// rests here with no wake pending, e.g. until an alarm
					if (bias_enable_cmd || wake_sb) begin
						state_next = ST_BIAS_WAIT;
						wake_seen_next = wake_sb;
						wake_flag_next = 1'b0;
					end
				end
				ST_BIAS_WAIT: begin
					if (bias_ready) begin
						state_next = ST_READY;
					end
				end
				ST_READY: begin
					if (wake_seen_reg || wake_sb) begin
						state_next = ST_POWER_UP;
					end
				end
				ST_POWER_UP: begin
					if (cnt_reg == 32'(SEQ_CNT - 1)) begin
						state_next = ST_ON;
					end
				end
				ST_ON: begin
					if (sleep_go) begin
						state_next = ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (wake_sl) begin
						state_next = ST_ON;
					end
				end
				ST_POWER_DOWN: begin
					if (cnt_reg == 32'(SEQ_CNT - 1)) begin
						state_next = ST_STANDBY;
						rreset_next = 1'b1;
						wake_seen_next = 1'b0;
					end
				end
				default: state_next = ST_NO_POWER;
			endcase
		end
		cnt_next = (state_next != state_reg) ? 32'h0 : cnt_reg + 32'h1;
	end

	// reset line: open-drain drive, release delay, held-low sense
	always_comb begin
		// a shutdown starting now pulls the line at the same edge as the record
		release_ok = state_reg inside {ST_POWER_UP, ST_ON, ST_SLEEP}
			&& !wd.expired && !seq_go && !imm && osc_stable && sequencer_reset_release;
		rst_cnt_next = 32'h0;
		oe_n_next = 1'b0;
		if (release_ok) begin
			if (rst_cnt_reg == 32'(RST_CNT - 1)) begin
				rst_cnt_next = rst_cnt_reg;
				oe_n_next = 1'b1;
			end else begin
				rst_cnt_next = rst_cnt_reg + 32'h1;
			end
		end
		// only an external low counts, never our own drive
		sensed = oe_n_reg && !reset_line_n_in;
		rsi_cnt_next = 32'h0;
		rsi_fired_next = 1'b0;
		rsi_ev_next = 1'b0;
		if (sensed) begin
			rsi_fired_next = rsi_fired_reg;
			rsi_cnt_next = rsi_cnt_reg;
			if (rsi_cnt_reg == 32'(DBNC_CNT - 1)) begin
				rsi_ev_next = !rsi_fired_reg;
				rsi_fired_next = 1'b1;
			end else begin
				rsi_cnt_next = rsi_cnt_reg + 32'h1;
			end
		end
		irq_oe_n_next = !pend;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_NO_POWER;
			cnt_reg <= 32'h0;
			rec_reg <= '0;
			wake_flag_reg <= 1'b0;
			wake_seen_reg <= 1'b0;
			rreset_reg <= 1'b0;
			regoff_reg <= 1'b1;
			mseq_reg <= 1'b0;
			sseq_reg <= 1'b0;
			prev_reg <= 5'h0;
			oe_n_reg <= 1'b0;
			irq_oe_n_reg <= 1'b1;
			rst_cnt_reg <= 32'h0;
			rsi_cnt_reg <= 32'h0;
			rsi_fired_reg <= 1'b0;
			rsi_ev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rec_reg <= rec_next;
			wake_flag_reg <= wake_flag_next;
			wake_seen_reg <= wake_seen_next;
			rreset_reg <= rreset_next;
			regoff_reg <= state_next <= ST_READY;
			mseq_reg <= state_next inside {ST_POWER_UP, ST_ON, ST_SLEEP};
			sseq_reg <= state_next inside {ST_POWER_UP, ST_ON};
			prev_reg <= prev_next;
			oe_n_reg <= oe_n_next;
			irq_oe_n_reg <= irq_oe_n_next;
			rst_cnt_reg <= rst_cnt_next;
			rsi_cnt_reg <= rsi_cnt_next;
			rsi_fired_reg <= rsi_fired_next;
			rsi_ev_reg <= rsi_ev_next;
		end
	end

	// open-drain pins only ever drive low
	assign reset_line_n_out = 1'b0;
	assign irq_out_n_out = 1'b0;
	assign reset_line_n_oe_n = oe_n_reg;
	assign irq_out_n_oe_n = irq_oe_n_reg;
	assign power_off_event_record = rec_reg;
	assign onoff_state = state_reg;
	assign regulators_off = regoff_reg;
	assign register_reset = rreset_reg;
	assign main_sequencer_up = mseq_reg;
	assign sleep_sequencer_up = sseq_reg;
	assign rtc_keep_alive = rst_n;
	assign wake_pending = wake_flag_reg;
	assign wdog_enable = wd.enable;

	a_release_conds_met: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(oe_n_reg) |-> $past(release_ok))
		else $error("reset line released without its conditions");
	a_cause_gets_recorded: assert property (@(posedge clk) disable iff (!rst_n)
		(seq_go && !imm && cause[PO_SFT]) |=> (rec_reg[PO_SFT] && state_reg == ST_POWER_DOWN))
		else $error("shutdown cause not recorded");
	a_auto_wake_set: assert property (@(posedge clk) disable iff (!rst_n)
		(seq_go && !imm && auto_wake) |=> wake_flag_reg)
		else $error("auto wake flag not set");
	a_off_no_wake: assert property (@(posedge clk) disable iff (!rst_n)
		(seq_go && !imm && !auto_wake) |=> !wake_flag_reg)
		else $error("off class shutdown left a wake flag");
	a_imm_shutdown_first: assert property (@(posedge clk) disable iff (!rst_n)
		(imm && state_reg != ST_NO_POWER) |=> (state_reg == ST_NO_POWER && register_reset))
		else $error("immediate shutdown did not win");
	a_irq_follows_pend: assert property (@(posedge clk) disable iff (!rst_n)
		pend ##1 pend |-> !irq_oe_n_reg)
		else $error("interrupt pin not low while pending");
	a_osc_to_standby: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_NO_POWER && osc_ok_signal && !imm) |=> state_reg == ST_STANDBY)
		else $error("no standby after oscillator ok");
	a_ready_waits_wake: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_READY && !wake_seen_reg && !wake_sb && !imm && !seq_go) |=> state_reg == ST_READY)
		else $error("ready left without a wakeup");
	a_rsi_single_event: assert property (@(posedge clk) disable iff (!rst_n)
		rsi_ev_reg |=> !rsi_ev_reg)
		else $error("reset input event repeated");
	a_record_stays_set: assert property (@(posedge clk) disable iff (!rst_n)
		(rec_reg[PO_OFF] && !power_off_record_clr[PO_OFF]) |=> rec_reg[PO_OFF])
		else $error("event record bit lost without a clear");
endmodule : pmoo_ctrl
`default_nettype wire

// ---- core/pmoo_end.sv ----
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- test/pmoo_ap_model.sv ----
// Purpose: processor side model, pulled-up reset and interrupt wires
// Assumes: both wires are open-drain with pull-ups
// Notes: the reset button pulls low only where the device leaves the wire free
`timescale 1ns/1ns
`default_nettype none
module pmoo_ap_model (
	input wire logic dev_rst_oe_n,
	input wire logic dev_irq_oe_n,
	input wire logic button_press,
	output logic reset_wire,
	output logic irq_wire
);
	// pull-up level unless any party drives low
	assign reset_wire = dev_rst_oe_n & ~button_press;
	assign irq_wire = dev_irq_oe_n;
endmodule : pmoo_ap_model
`default_nettype wire

// ---- test/tb_pmoo_ctrl.sv ----
// Purpose: self-checking bench of the on/off controller
// Assumes: short sim counts, inputs driven at the falling edge
// Notes: row table walks six of the sequenced shutdown causes
`timescale 1ns/1ns
`default_nettype none
module tb_pmoo_ctrl;
	import pmoo_pkg::*;
	logic clk, rst_b, reset_line_n_in, reset_line_n_out, reset_line_n_oe_n, irq_out_n_out, irq_out_n_oe_n, btn, irq_w;
	logic [7:0] irq_status, irq_mask;
	logic osc_ok_signal, osc_stable, sequencer_reset_release, bias_enable_cmd, bias_ready, main_battery_reset_low;
	logic main_battery_uvlo, main_battery_ovlo, thermal_overload, shutdown_input, manual_reset_event;
	logic manual_reset_wake_fuse, soft_reset_cmd, soft_reset_wake, power_off_cmd, wdog_reset_wake;
	logic main_seq_sw_source, main_seq_sw_enable, sleep_seq_sw_source, sleep_seq_sw_enable, wdog_enable_fuse;
	logic wdog_enable_wr, wdog_enable_wdata, wdog_clear_wr, wdog_auto_clear, key_polarity_fuse;
	logic [1:0] wdog_clear_field, wdog_period_sel, key_mode_fuse;
	logic sleep_polarity_fuse, power_key_input, sleep_control_input, sleep_allow, adapter_present, alarm_one_event;
	logic alarm_two_event, sudden_loss_wake, sudden_loss_wake_en, wake_mask_key, wake_mask_alarm_one;
	logic wake_mask_alarm_two, wake_mask_adapter, wake_mask_battery;
	logic [8:0] power_off_record_clr, power_off_event_record;
	logic [2:0] onoff_state;
	logic regulators_off, register_reset, main_sequencer_up, sleep_sequencer_up, rtc_keep_alive, wake_pending, wdog_enable;
	int num_errors = 0;
	int check_count = 0;
	// rows: cause source, wake bit, record bit
	localparam logic [7:0] ROWS [8] = '{8'h04, 8'h14, 8'h25, 8'h46, 8'h67, 8'h82, 8'h92, 8'ha3};
	logic [7:0] r;
	pmoo_ctrl #(.RST_CNT(4), .DBNC_CNT(4), .BIAS_READY_CNT(8), .WD_TICK(4), .SEQ_CNT(4)) uut (.*);
	pmoo_ap_model ap (.dev_rst_oe_n(reset_line_n_oe_n), .dev_irq_oe_n(irq_out_n_oe_n), .button_press(btn),
		.reset_wire(reset_line_n_in), .irq_wire(irq_w));
	always #5 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	// bounded wait so a stuck state machine cannot hang the run
	task automatic wait_st(input logic [2:0] s, input int n);
		for (int i = 0; i < n && onoff_state !== s; i++) cyc(1);
	endtask : wait_st
	task automatic wake_up;
		alarm_one_event = 1'b1;
		cyc(1);
		alarm_one_event = 1'b0;
		wait_st(3'h5, 60);
	endtask : wake_up
	task automatic report_and_stop;
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		#60000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		{clk, rst_b, btn, irq_status, irq_mask, osc_ok_signal, bias_enable_cmd, main_battery_reset_low, main_battery_uvlo,
			main_battery_ovlo, thermal_overload, shutdown_input, manual_reset_event, manual_reset_wake_fuse, soft_reset_cmd,
			soft_reset_wake, power_off_cmd, wdog_reset_wake, main_seq_sw_source, main_seq_sw_enable, sleep_seq_sw_source,
			sleep_seq_sw_enable, wdog_enable_fuse, wdog_enable_wr, wdog_enable_wdata, wdog_clear_wr, wdog_auto_clear,
			key_polarity_fuse, wdog_clear_field, wdog_period_sel, key_mode_fuse, power_key_input, sleep_control_input,
			sleep_allow, adapter_present, alarm_one_event, alarm_two_event, sudden_loss_wake, sudden_loss_wake_en,
			wake_mask_key, wake_mask_alarm_two, wake_mask_adapter, wake_mask_battery, power_off_record_clr} = '0;
		{osc_stable, sequencer_reset_release, bias_ready, wake_mask_alarm_one, sleep_polarity_fuse} = '1;
		cyc(2);
		chk("state", 0, onoff_state);
		chk("regs_off", 1, regulators_off);
		chk("rst_oe_n", 0, reset_line_n_oe_n);
		rst_b = 1'b1;
		cyc(3);
		osc_ok_signal = 1'b1;
		wait_st(3'h1, 5);
		chk("standby", 1, onoff_state);
		bias_enable_cmd = 1'b1;
		cyc(1);
		bias_enable_cmd = 1'b0;
		cyc(12);
		chk("ready", 3, onoff_state);
		wake_up();
		chk("on", 5, onoff_state);
		chk("seq_up", 6, {main_sequencer_up, sleep_sequencer_up, regulators_off});
		chk("pin_out", 0, {reset_line_n_out, irq_out_n_out});
		for (int i = 0; i < 20 && reset_line_n_oe_n !== 1'b1; i++) cyc(1);
		chk("rst_wire", 1, reset_line_n_in);
		irq_status = 8'h81;
		irq_mask = 8'h80;
		cyc(2);
		chk("irq", 0, irq_w);
		irq_mask = 8'h81;
		cyc(2);
		chk("irq", 1, irq_w);
		// each row's sequenced cause from the on state, record cleared first
		for (int k = 0; k < 8; k++) begin
			r = ROWS[k];
			if (onoff_state !== 3'h5) wake_up();
			power_off_record_clr = '1;
			cyc(1);
			power_off_record_clr = '0;
			chk("rec_clr", 0, power_off_event_record);
			{soft_reset_wake, manual_reset_wake_fuse} = {2{r[4]}};
			case (r[7:5])
				3'h0: soft_reset_cmd = 1'b1;
				3'h1: power_off_cmd = 1'b1;
				3'h2: thermal_overload = 1'b1;
				3'h3: shutdown_input = 1'b1;
				default: manual_reset_event = 1'b1;
				3'h5: begin
					{wdog_enable_wr, wdog_enable_wdata} = 2'h3;
					cyc(1);
					chk("wd_en", 1, wdog_enable);
					{wdog_enable_wr, wdog_clear_field} = 3'h1;
					repeat (4) begin
						cyc(5);
						wdog_clear_wr = 1'b1;
						cyc(1);
						wdog_clear_wr = 1'b0;
					end
					chk("wd_clear", 0, power_off_event_record);
				end
			endcase
			cyc(1);
			{soft_reset_cmd, power_off_cmd, manual_reset_event} = '0;
			for (int i = 0; i < 60 && power_off_event_record[r[3:0]] !== 1'b1; i++) cyc(1);
			chk("record", 16'h1 << r[3:0], power_off_event_record);
			chk("rst_drive", 0, reset_line_n_oe_n);
			{thermal_overload, shutdown_input} = '0;
			cyc(40);
			chk("end_state", r[4] ? 5 : 1, onoff_state);
			chk("rtc", 1, rtc_keep_alive);
		end
		// held external reset: only sensed while the device lets the wire go, so wake first
		wake_up();
		power_off_record_clr = '1;
		cyc(1);
		power_off_record_clr = '0;
		btn = 1'b1;
		for (int i = 0; i < 40 && power_off_event_record[PO_RSI] !== 1'b1; i++) cyc(1);
		btn = 1'b0;
		chk("rsi_rec", 16'h1 << PO_RSI, power_off_event_record);
		chk("wake_flag", 1, wake_pending);
		cyc(40);
		chk("rsi_wake", 5, onoff_state);
		// sleep entry on a fall of the control input, exit on its rise
		{sleep_allow, sleep_control_input} = 2'h3;
		cyc(1);
		sleep_control_input = 1'b0;
		cyc(2);
		chk("sleep", 6, onoff_state);
		chk("sleep_seq", 0, sleep_sequencer_up);
		sleep_control_input = 1'b1;
		cyc(2);
		chk("sleep_exit", 5, onoff_state);
		power_off_record_clr = '1;
		{main_battery_uvlo, power_off_cmd} = 2'h3;
		cyc(1);
		{power_off_record_clr, main_battery_uvlo, power_off_cmd} = '0;
		chk("immediate", 0, onoff_state);
		chk("imm_rec", 0, power_off_event_record);
		chk("reg_reset", 1, register_reset);
		wait_st(3'h1, 5);
		chk("restart", 1, onoff_state);
		// bias never ready: timer runs out and the controller drops to no power
		bias_ready = 1'b0;
		bias_enable_cmd = 1'b1;
		cyc(1);
		bias_enable_cmd = 1'b0;
		cyc(8);
		chk("bias_ready_timeout", 0, onoff_state);
		bias_ready = 1'b1;
		// second reset in mid-run
		rst_b = 1'b0;
		cyc(1);
		chk("rst_state", 0, onoff_state);
		chk("rst_oe_n", 0, reset_line_n_oe_n);
		rst_b = 1'b1;
		cyc(3);
		chk("rst_standby", 1, onoff_state);
		report_and_stop();
	end
endmodule : tb_pmoo_ctrl
`default_nettype wire
